// ---- common/link_regs_pkg.sv ----
// Package of offsets, field positions and constants for the link control and status registers
package link_regs_pkg;

  // ************************************************************
  // Register offsets in configuration space
  // ************************************************************
  localparam logic [7:0] LINK_CONTROL_OFFSET = 8'h80; // Control word
  localparam logic [7:0] LINK_STATUS_OFFSET = 8'h82;  // Status word

  // ************************************************************
  // Link control field positions
  // ************************************************************
  localparam int CTRL_CLOCK_PM_BIT = 8;       // Clock request power management
  localparam int CTRL_EXT_SYNCH_BIT = 7;      // Extended synch
  localparam int CTRL_COMMON_CLOCK_BIT = 6;   // Common clock configuration
  localparam int CTRL_COMPL_BOUNDARY_BIT = 3; // Read completion boundary
  localparam int CTRL_LPE_LSB = 0;            // Low-power entry control, two bits
  localparam logic [15:0] LINK_CONTROL_RESET = 16'h0000; // Value after reset

  // ************************************************************
  // Low-power entry encodings
  // ************************************************************
  localparam logic [1:0] LPE_DISABLED = 2'h0; // No active-state power management
  localparam logic [1:0] LPE_STANDBY = 2'h1;  // Standby entry allowed
  localparam logic [1:0] LPE_DEEP = 2'h2;     // Deep state entry allowed
  localparam logic [1:0] LPE_BOTH = 2'h3;     // Both allowed

  // ************************************************************
  // Link status field positions and fixed values
  // ************************************************************
  localparam int STAT_SLOT_CLOCK_BIT = 12; // Slot clock shared, always one
  localparam int STAT_WIDTH_LSB = 4;       // Negotiated width, six bits
  localparam int STAT_SPEED_LSB = 0;       // Current link speed, four bits
  localparam logic [5:0] ACTIVE_LANE_COUNT = 6'h01; // Single lane
  localparam logic [3:0] SPEED_2G5 = 4'h1;          // 2.5 Gb/s code
  localparam logic [3:0] SPEED_5G = 4'h2;           // 5 Gb/s code
  localparam logic [3:0] SPEED_RESET = 4'h1;        // Shown before training reports

  // ************************************************************
  // Exit latency reset value
  // ************************************************************
  localparam logic [2:0] EXIT_LAT_RESET = 3'h0; // Mirror output after reset

endpackage

// ---- verilog/exit_latency_select.sv ----
// Selects the reported exit latencies from the asynchronous or shared-clock values
module exit_latency_select
(
  input wire logic sys_clk_in,                      // System clock
  input wire logic rst_in,                          // Synchronous reset, active high
  input wire logic common_clock_in,                 // Common clock bit of link control
  input wire logic [2:0] standby_exit_async_value_in,  // Standby latency, separate clocks
  input wire logic [2:0] standby_exit_shared_value_in, // Standby latency, shared clock
  input wire logic [2:0] deep_exit_async_value_in,     // Deep latency, separate clocks
  input wire logic [2:0] deep_exit_shared_value_in,    // Deep latency, shared clock
  output logic [2:0] standby_exit_latency_out,       // Reported standby exit latency
  output logic [2:0] deep_exit_latency_out           // Reported deep exit latency
);

  // ************************************************************
  // Selection state
  // ************************************************************
  logic [2:0] standby_reg;  // Registered standby latency
  logic [2:0] standby_next; // Its next value
  logic [2:0] deep_reg;     // Registered deep latency
  logic [2:0] deep_next;    // Its next value

  // Pick the pair that matches the clocking arrangement
  always_comb
  begin
    if (common_clock_in)
    begin
      // Shared reference clock
      standby_next = standby_exit_shared_value_in;
      deep_next = deep_exit_shared_value_in;
    end
    else
    begin
      // Separate reference clocks
      standby_next = standby_exit_async_value_in;
      deep_next = deep_exit_async_value_in;
    end
  end

  // Register so the outputs come straight from flops
  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
    begin
      standby_reg <= link_regs_pkg::EXIT_LAT_RESET;
      deep_reg <= link_regs_pkg::EXIT_LAT_RESET;
    end
    else
    begin
      standby_reg <= standby_next;
      deep_reg <= deep_next;
    end
  end

  assign standby_exit_latency_out = standby_reg;
  assign deep_exit_latency_out = deep_reg;

endmodule

// ---- verilog/link_ctrl_status_regs.sv ----
// Link control and link status registers reached by configuration accesses

module link_ctrl_status_regs
(
  input wire logic sys_clk_in,                   // System clock, 100 MHz
  input wire logic rst_in,                       // Synchronous reset, active high
  input wire logic cfg_wr_in,                    // Configuration write strobe
  input wire logic cfg_rd_in,                    // Configuration read strobe
  input wire logic [7:0] cfg_addr_in,            // Byte offset in configuration space
  input wire logic [1:0] cfg_be_in,              // Byte enables of the 16-bit word
  input wire logic [15:0] cfg_wdata_in,          // Write data
  input wire logic link_up_in,                   // Link training finished
  input wire logic link_5g_in,                   // Link trained at 5 Gb/s
  input wire logic [2:0] standby_exit_async_value_in,  // Standby latency, separate clocks
  input wire logic [2:0] standby_exit_shared_value_in, // Standby latency, shared clock
  input wire logic [2:0] deep_exit_async_value_in,     // Deep latency, separate clocks
  input wire logic [2:0] deep_exit_shared_value_in,    // Deep latency, shared clock
  output logic [15:0] cfg_rdata_out,             // Read data
  output logic cfg_rvalid_out,                   // Read data valid, one cycle
  output logic [1:0] low_power_entry_control_out, // Active-state entry permission
  output logic clock_request_pm_enable_out,      // Clock power management enable
  output logic extended_synch_out,               // Extended synch enable
  output logic completion_boundary_out,          // Read completion boundary
  output logic common_clock_out,                 // Common clock configuration
  output logic [3:0] current_link_speed_out,     // Negotiated speed code
  output logic [2:0] standby_exit_latency_out,   // Reported standby exit latency
  output logic [2:0] deep_exit_latency_out       // Reported deep exit latency
);

  // ************************************************************
  // Control state
  // ************************************************************
  logic [1:0] lpe_reg;      // Low-power entry control
  logic [1:0] lpe_next;
  logic clk_pm_reg;         // Clock request power management enable
  logic clk_pm_next;
  logic ext_synch_reg;      // Extended synch
  logic ext_synch_next;
  logic common_clock_reg;   // Common clock configuration
  logic common_clock_next;
  logic boundary_reg;       // Read completion boundary
  logic boundary_next;

  // ************************************************************
  // Status and read path state
  // ************************************************************
  logic [3:0] speed_reg;    // Negotiated speed code
  logic [3:0] speed_next;
  logic [15:0] rdata_reg;   // Read data holding register
  logic [15:0] rdata_next;
  logic rvalid_reg;         // Read answer marker
  logic rvalid_next;

  // ************************************************************
  // Assembled register images
  // ************************************************************
  logic [15:0] control_image; // Control word as software reads it
  logic [15:0] status_image;  // Status word as software reads it
  logic ctrl_hit;             // Access targets the control word
  logic stat_hit;             // Access targets the status word

  // Address decode; only exact word offsets are claimed
  always_comb
  begin
    ctrl_hit = (cfg_addr_in == link_regs_pkg::LINK_CONTROL_OFFSET);
    stat_hit = (cfg_addr_in == link_regs_pkg::LINK_STATUS_OFFSET);
  end

  // Control image: unlisted bits stay zero, covering reserved and inert bits
  always_comb
  begin
    control_image = 16'h0000;
    control_image[link_regs_pkg::CTRL_CLOCK_PM_BIT] = clk_pm_reg;
    control_image[link_regs_pkg::CTRL_EXT_SYNCH_BIT] = ext_synch_reg;
    control_image[link_regs_pkg::CTRL_COMMON_CLOCK_BIT] = common_clock_reg;
    control_image[link_regs_pkg::CTRL_COMPL_BOUNDARY_BIT] = boundary_reg;
    control_image[link_regs_pkg::CTRL_LPE_LSB +: 2] = lpe_reg;
  end

  // Status image: flags with no function are held at zero
  always_comb
  begin
    status_image = 16'h0000;
    status_image[link_regs_pkg::STAT_SLOT_CLOCK_BIT] = 1'b1;
    status_image[link_regs_pkg::STAT_WIDTH_LSB +: 6] = link_regs_pkg::ACTIVE_LANE_COUNT;
    status_image[link_regs_pkg::STAT_SPEED_LSB +: 4] = speed_reg;
  end

  // Next control values; each byte lane writes only its own bits
  always_comb
  begin
    lpe_next = lpe_reg;
    clk_pm_next = clk_pm_reg;
    ext_synch_next = ext_synch_reg;
    common_clock_next = common_clock_reg;
    boundary_next = boundary_reg;
    if (cfg_wr_in && ctrl_hit)
    begin
      // Low lane holds bits 7:0; bits 5, 4 and 2 are simply not stored
      if (cfg_be_in[0])
      begin
        lpe_next = cfg_wdata_in[link_regs_pkg::CTRL_LPE_LSB +: 2];
        ext_synch_next = cfg_wdata_in[link_regs_pkg::CTRL_EXT_SYNCH_BIT];
        common_clock_next = cfg_wdata_in[link_regs_pkg::CTRL_COMMON_CLOCK_BIT];
        boundary_next = cfg_wdata_in[link_regs_pkg::CTRL_COMPL_BOUNDARY_BIT];
      end
      // High lane holds bit 8; bits 15:9 are dropped
      if (cfg_be_in[1])
      begin
        clk_pm_next = cfg_wdata_in[link_regs_pkg::CTRL_CLOCK_PM_BIT];
      end
    end
  end

  // Register the control fields
  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
    begin
      // All writable fields start cleared
      lpe_reg <= link_regs_pkg::LINK_CONTROL_RESET[link_regs_pkg::CTRL_LPE_LSB +: 2];
      clk_pm_reg <= link_regs_pkg::LINK_CONTROL_RESET[link_regs_pkg::CTRL_CLOCK_PM_BIT];
      ext_synch_reg <= link_regs_pkg::LINK_CONTROL_RESET[link_regs_pkg::CTRL_EXT_SYNCH_BIT];
      common_clock_reg <= link_regs_pkg::LINK_CONTROL_RESET[link_regs_pkg::CTRL_COMMON_CLOCK_BIT];
      boundary_reg <= link_regs_pkg::LINK_CONTROL_RESET[link_regs_pkg::CTRL_COMPL_BOUNDARY_BIT];
    end
    else
    begin
      lpe_reg <= lpe_next;
      clk_pm_reg <= clk_pm_next;
      ext_synch_reg <= ext_synch_next;
      common_clock_reg <= common_clock_next;
      boundary_reg <= boundary_next;
    end
  end

  // Speed tracking; the code holds its last value while the link is down
  // so software still sees the most recent outcome
  always_comb
  begin
    speed_next = speed_reg;
    if (link_up_in)
    begin
      if (link_5g_in)
      begin
        speed_next = link_regs_pkg::SPEED_5G;
      end
      else
      begin
        speed_next = link_regs_pkg::SPEED_2G5;
      end
    end
  end

  // Read path; unmapped offsets answer zero so the requester never hangs
  always_comb
  begin
    rvalid_next = cfg_rd_in;
    rdata_next = 16'h0000;
    if (cfg_rd_in)
    begin
      if (ctrl_hit)
      begin
        rdata_next = control_image;
      end
      else if (stat_hit)
      begin
        rdata_next = status_image;
      end
    end
  end

  // Register status and read answer
  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
    begin
      speed_reg <= link_regs_pkg::SPEED_RESET;
      rdata_reg <= 16'h0000;
      rvalid_reg <= 1'b0;
    end
    else
    begin
      speed_reg <= speed_next;
      rdata_reg <= rdata_next;
      rvalid_reg <= rvalid_next;
    end
  end

  // ************************************************************
  // Exit latency mirror
  // ************************************************************
  // Driven from the stored bit, which is registered again inside, so the latency outputs change two cycles after the write
  exit_latency_select latency_select
  (
    .sys_clk_in(sys_clk_in),
    .rst_in(rst_in),
    .common_clock_in(common_clock_reg),
    .standby_exit_async_value_in(standby_exit_async_value_in),
    .standby_exit_shared_value_in(standby_exit_shared_value_in),
    .deep_exit_async_value_in(deep_exit_async_value_in),
    .deep_exit_shared_value_in(deep_exit_shared_value_in),
    .standby_exit_latency_out(standby_exit_latency_out),
    .deep_exit_latency_out(deep_exit_latency_out)
  );

  // ************************************************************
  // Outputs, all from flops
  // ************************************************************
  assign cfg_rdata_out = rdata_reg;
  assign cfg_rvalid_out = rvalid_reg;
  assign low_power_entry_control_out = lpe_reg;
  assign clock_request_pm_enable_out = clk_pm_reg;
  assign extended_synch_out = ext_synch_reg;
  assign completion_boundary_out = boundary_reg;
  assign common_clock_out = common_clock_reg;
  assign current_link_speed_out = speed_reg;

endmodule

// ---- verif/link_regs_sva.sv ----
// Checker for the link control and status register block
module link_regs_sva
(
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic cfg_wr_in,
  input wire logic cfg_rd_in,
  input wire logic [7:0] cfg_addr_in,
  input wire logic [1:0] cfg_be_in,
  input wire logic [15:0] cfg_wdata_in,
  input wire logic link_up_in,
  input wire logic link_5g_in,
  input wire logic [2:0] standby_exit_async_value_in,
  input wire logic [2:0] standby_exit_shared_value_in,
  input wire logic [2:0] deep_exit_async_value_in,
  input wire logic [2:0] deep_exit_shared_value_in,
  input wire logic [15:0] cfg_rdata_out,
  input wire logic cfg_rvalid_out,
  input wire logic [1:0] low_power_entry_control_out,
  input wire logic clock_request_pm_enable_out,
  input wire logic extended_synch_out,
  input wire logic completion_boundary_out,
  input wire logic common_clock_out,
  input wire logic [3:0] current_link_speed_out
);
  timeunit 1ns;
  timeprecision 100ps;
  // ************************************************************
  // Control word as seen on the outputs
  // ************************************************************
  default clocking @(posedge sys_clk_in);
  endclocking
  default disable iff (rst_in);
  logic [15:0] ctrl_view; // Reserved and inert bits forced to zero
  assign ctrl_view = {7'h00, clock_request_pm_enable_out, extended_synch_out,
    common_clock_out, 2'h0, completion_boundary_out, 1'h0, low_power_entry_control_out};
  a_read_answered: assert property (cfg_rd_in |=> cfg_rvalid_out)
    else $error("read strobe not answered");
  a_no_stray_valid: assert property (!cfg_rd_in |=> !cfg_rvalid_out)
    else $error("valid without read");
  a_status_fixed_bits: assert property (cfg_rd_in && cfg_addr_in == 8'h82 |=>
    cfg_rdata_out[15:4] == 12'h101) else $error("status fixed bits wrong");
  a_ctrl_readback: assert property (cfg_rd_in && cfg_addr_in == 8'h80 |=>
    cfg_rdata_out == $past(ctrl_view)) else $error("control readback wrong");
  a_ctrl_full_write: assert property (cfg_wr_in && cfg_addr_in == 8'h80 && cfg_be_in == 2'h3
    |=> ctrl_view == ($past(cfg_wdata_in) & 16'h01cb)) else $error("control write wrong");
  a_ctrl_hold: assert property (!(cfg_wr_in && cfg_addr_in == 8'h80) |=> $stable(ctrl_view))
    else $error("control changed without write");
  a_speed_track: assert property (link_up_in |=> current_link_speed_out ==
    ($past(link_5g_in) ? 4'h2 : 4'h1)) else $error("speed code wrong");
  a_speed_hold: assert property (!link_up_in |=> $stable(current_link_speed_out))
    else $error("speed changed while link down");
endmodule
bind link_ctrl_status_regs link_regs_sva link_regs_sva_i (.*);

// ---- verif/rc_model.sv ----
// Root complex model issuing configuration reads and writes
module rc_model
(
  input wire logic sys_clk_in,
  input wire logic [15:0] cfg_rdata_in,
  input wire logic cfg_rvalid_in,
  output logic cfg_wr_out,
  output logic cfg_rd_out,
  output logic [7:0] cfg_addr_out,
  output logic [1:0] cfg_be_out,
  output logic [15:0] cfg_wdata_out
);
  timeunit 1ns;
  timeprecision 100ps;
  initial
  begin
    cfg_wr_out = 1'b0;
    cfg_rd_out = 1'b0;
    cfg_addr_out = 8'h00;
    cfg_be_out = 2'h0;
    cfg_wdata_out = 16'h0000;
  end
  // Idle bus shows inverted values so stale data is never mistaken for valid
  task automatic idle();
    cfg_wr_out = 1'b0;
    cfg_rd_out = 1'b0;
    cfg_addr_out = ~cfg_addr_out;
    cfg_wdata_out = ~cfg_wdata_out;
  endtask
  // Software picks the clock arrangement through these writes
  task automatic cfg_write(input logic [7:0] a, input logic [1:0] b, input logic [15:0] d);
    @(posedge sys_clk_in);
    #1;
    cfg_wr_out = 1'b1;
    cfg_addr_out = a;
    cfg_be_out = b;
    cfg_wdata_out = d;
    @(posedge sys_clk_in);
    #1;
    idle();
  endtask
  // Read waits a bounded number of cycles for the valid pulse
  task automatic cfg_read(input logic [7:0] a, output logic [15:0] d, output logic ok);
    @(posedge sys_clk_in);
    #1;
    cfg_rd_out = 1'b1;
    cfg_addr_out = a;
    @(posedge sys_clk_in);
    #1;
    idle();
    ok = 1'b0;
    d = 16'h0000;
    for (int i = 0; i < 4 && !ok; i++)
    begin
      if (cfg_rvalid_in === 1'b1)
      begin
        ok = 1'b1;
        d = cfg_rdata_in;
      end
      else
        @(posedge sys_clk_in) #1;
    end
  endtask
endmodule

// ---- verif/tb.sv ----
// Self-checking bench for the link control and status registers
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic sys_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic cfg_wr_in, cfg_rd_in, cfg_rvalid_out, link_up_in, link_5g_in;
  logic [7:0] cfg_addr_in;
  logic [1:0] cfg_be_in, low_power_entry_control_out;
  logic [15:0] cfg_wdata_in, cfg_rdata_out;
  logic clock_request_pm_enable_out, extended_synch_out, completion_boundary_out;
  logic common_clock_out;
  logic [3:0] current_link_speed_out;
  logic [2:0] standby_exit_latency_out, deep_exit_latency_out;
  logic [2:0] standby_exit_async_value_in = 3'h1; // Distinct sources expose a wrong pick
  logic [2:0] standby_exit_shared_value_in = 3'h2;
  logic [2:0] deep_exit_async_value_in = 3'h3;
  logic [2:0] deep_exit_shared_value_in = 3'h4;
  logic [15:0] outs; // Control outputs packed as the register reads
  logic [15:0] lats; // Both reported latencies
  int num_errors = 0;
  int compares = 0;
  assign outs = {7'h00, clock_request_pm_enable_out, extended_synch_out,
    common_clock_out, 2'h0, completion_boundary_out, 1'h0, low_power_entry_control_out};
  assign lats = {10'h000, standby_exit_latency_out, deep_exit_latency_out};
  always #5 sys_clk_in = ~sys_clk_in;
  initial
  begin
    link_up_in = 1'b0;
    link_5g_in = 1'b0;
  end
  link_ctrl_status_regs link_ctrl_status_regs_i
  (
    .sys_clk_in(sys_clk_in),
    .rst_in(rst_in),
    .cfg_wr_in(cfg_wr_in),
    .cfg_rd_in(cfg_rd_in),
    .cfg_addr_in(cfg_addr_in),
    .cfg_be_in(cfg_be_in),
    .cfg_wdata_in(cfg_wdata_in),
    .link_up_in(link_up_in),
    .link_5g_in(link_5g_in),
    .standby_exit_async_value_in(standby_exit_async_value_in),
    .standby_exit_shared_value_in(standby_exit_shared_value_in),
    .deep_exit_async_value_in(deep_exit_async_value_in),
    .deep_exit_shared_value_in(deep_exit_shared_value_in),
    .cfg_rdata_out(cfg_rdata_out),
    .cfg_rvalid_out(cfg_rvalid_out),
    .low_power_entry_control_out(low_power_entry_control_out),
    .clock_request_pm_enable_out(clock_request_pm_enable_out),
    .extended_synch_out(extended_synch_out),
    .completion_boundary_out(completion_boundary_out),
    .common_clock_out(common_clock_out),
    .current_link_speed_out(current_link_speed_out),
    .standby_exit_latency_out(standby_exit_latency_out),
    .deep_exit_latency_out(deep_exit_latency_out)
  );
  rc_model rc_model_i (.sys_clk_in(sys_clk_in), .cfg_rdata_in(cfg_rdata_out),
    .cfg_rvalid_in(cfg_rvalid_out), .cfg_wr_out(cfg_wr_in), .cfg_rd_out(cfg_rd_in),
    .cfg_addr_out(cfg_addr_in), .cfg_be_out(cfg_be_in), .cfg_wdata_out(cfg_wdata_in));
  // ************************************************************
  // Checking and closing
  // ************************************************************
  task automatic test_done();
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // A read that never answers ends the run as a failure
  task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
    logic [15:0] d;
    logic ok;
    rc_model_i.cfg_read(a, d, ok);
    if (ok !== 1'b1)
    begin
      num_errors++;
      test_done();
    end
    else
      chk(d, exp);
  endtask
  // ************************************************************
  // Main sequence
  // ************************************************************
  initial
  begin
    repeat (4) @(posedge sys_clk_in);
    #1;
    rst_in = 1'b0;
    chk(outs, 16'h0000);
    rd_chk(8'h80, 16'h0000);
    rd_chk(8'h82, 16'h1011);
    rc_model_i.cfg_write(8'h80, 2'h3, 16'hffff);
    chk(outs, 16'h01cb);
    rd_chk(8'h80, 16'h01cb);
    chk(lats, 16'h0014);
    rc_model_i.cfg_write(8'h80, 2'h1, 16'h0000);
    rd_chk(8'h80, 16'h0100);
    chk(lats, 16'h000b);
    for (int i = 0; i < 4; i++)
    begin
      rc_model_i.cfg_write(8'h80, 2'h3, 16'(i));
      rd_chk(8'h80, 16'(i));
    end
    rc_model_i.cfg_write(8'h82, 2'h3, 16'hffff);
    rc_model_i.cfg_write(8'h40, 2'h3, 16'hffff);
    rd_chk(8'h80, 16'h0003);
    rd_chk(8'h82, 16'h1011);
    rd_chk(8'h44, 16'h0000);
    link_up_in = 1'b1;
    link_5g_in = 1'b1;
    rd_chk(8'h82, 16'h1012);
    chk({12'h000, current_link_speed_out}, 16'h0002);
    link_up_in = 1'b0;
    link_5g_in = 1'b0;
    rd_chk(8'h82, 16'h1012);
    link_up_in = 1'b1;
    rd_chk(8'h82, 16'h1011);
    rc_model_i.cfg_write(8'h80, 2'h3, 16'h0040);
    rst_in = 1'b1;
    @(posedge sys_clk_in) #1;
    rst_in = 1'b0;
    chk(outs, 16'h0000);
    rd_chk(8'h80, 16'h0000);
    rd_chk(8'h82, 16'h1011);
    chk(lats, 16'h000b);
    test_done();
  end
endmodule
